// ### rtl/cpc_pkg.sv
package cpc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_IST = 8'h00;
  localparam logic [7:0] ADDR_IEN = 8'h04;
  localparam logic [7:0] ADDR_CTL = 8'h08;
  localparam logic [7:0] ADDR_BRPR = 8'h0c;
  localparam logic [7:0] ADDR_BTM = 8'h10;
  localparam logic [7:0] ADDR_TEC = 8'h14;
  localparam logic [7:0] ADDR_REC = 8'h18;
  localparam logic [7:0] ADDR_LID = 8'h1c;
  localparam logic [7:0] ADDR_PAGE = 8'h20;
  localparam logic [7:0] ADDR_LAST_DATA = 8'h24;
  localparam logic [7:0] ADDR_BUF1 = 8'h28;
  localparam logic [7:0] ADDR_BUF2 = 8'h2c;
  localparam logic [7:0] ADDR_BUF3 = 8'h30;
  // reset values
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] BRPR_RST = 8'h00;
  localparam logic [7:0] BTM_RST = 8'h23;
  // interrupt control bits
  localparam int IEN_EARLY = 0;
  localparam int IEN_TERR = 1;
  localparam int IEN_OVR = 2;
  localparam int IEN_STCH = 3;
  localparam int IEN_TX = 4;
  localparam int IEN_RX = 5;
  localparam int IEN_RXERR = 6;
  // control/status bits
  localparam int CTL_RUN = 0;
  localparam int CTL_WAKE = 1;
  localparam int CTL_FAST = 2;
  localparam int CTL_ONCE = 3;
  localparam int CTL_SELF = 4;
  // interrupt status bits
  localparam int IST_TERR = 1;
  localparam int IST_OVR = 2;
  localparam int IST_STCH = 3;
  localparam int IST_TXDN = 4;
  localparam int IST_RX1 = 5;
  // buffer control/status bits
  localparam int BC_RDY = 0;
  localparam int BC_LOCK = 1;
  localparam int BC_BUSY = 2;
  localparam int BC_FILT = 3;
  // protocol counts
  localparam int RECESSIVE_RUN = 11;
  localparam int RESYNC_RUNS = 128;
  localparam logic [8:0] TEC_STEP = 9'h008;
  localparam logic [7:0] PASSIVE_LIM = 8'h7f;
  // core states, gray along standby-wake-resync-idle-tx-rx
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000, ST_WAKE = 3'b001, ST_RESYNC = 3'b011,
    ST_IDLE = 3'b010, ST_TX = 3'b110, ST_RX = 3'b111
  } cpc_state_t;
  typedef enum logic [1:0] {SEG_SYNC = 2'b00, SEG_ONE = 2'b01, SEG_TWO = 2'b11} cpc_seg_t;
  // events from the frame engine
  typedef struct packed {
    logic sof;
    logic arb_won;
    logic arb_lost;
    logic tx_ok;
    logic tx_err;
    logic rx_ok;
    logic rx_err;
    logic own;
    logic [1:0] filt;
    logic [10:0] id;
    logic tx_bit;
  } cpc_fe_evt_t;
  // controls to the frame engine
  typedef struct packed {
    logic tx_start;
    logic [1:0] tx_buf;
    logic sample;
    logic bit_val;
    logic tx_point;
    logic active;
  } cpc_fe_ctl_t;
endpackage : cpc_pkg

// ### rtl/cpc_core.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - reset or run clear enters standby
// - finish transfer first; run reads 1 meanwhile
// - standby watches dominant bit, wake flag
// - run set: wake pulse or direct resync
// - wake state drives dominant one bit
// - resync 128 runs of 11, fast one
// - transmit priority buffer 3, 2, 1
// - retry until success or cancel cause
// - pending during job, busy while sending
// - done or error flag, enabled interrupt
// - early transmit: flag at arbitration, unlock
// - early transmit holds arbitrating buffer
// - store in lowest free buffer 1-3
// - no free buffer: overrun, keep identifier
// - store sets filter, pending, receive flag
// - two error counters, status change interrupt
// - sync, segment one, segment two, jump
// - valid edge lengthens or shortens segment
// - timing registers writable only in standby
// - receive flag cleared by software or pending
// - status change flag sources
// - error pending follows three error flags
module cpc_core #(
  parameter int RUN_BITS = cpc_pkg::RECESSIVE_RUN,
  parameter int RUN_COUNT = cpc_pkg::RESYNC_RUNS
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // can pins
  input wire logic can_rx_in,
  output logic can_tx_out,
  // frame engine
  input wire cpc_pkg::cpc_fe_evt_t fe_evt_in,
  output cpc_pkg::cpc_fe_ctl_t fe_ctl_out,
  // interrupt request
  output logic irq_out
);
  if (RUN_BITS < 2 || RUN_BITS > 15 || RUN_COUNT < 1 || RUN_COUNT > 255) begin : g_chk
    $error("cpc_core: resync counts out of range");
  end

  cpc_pkg::cpc_state_t state;
  cpc_pkg::cpc_seg_t seg;
  logic rx_m, rx_s, rx_d;
  logic [7:0] ien, ctl, brpr, btm, rec;
  logic [8:0] tec;
  logic [2:0] page_select;
  logic [10:0] last_ident;
  logic [2:0] pending, lock, busy, tx_job, receive_flag;
  logic [1:0] matched_filter_field [3];
  logic transmit_done_flag, transmit_error_flag, status_change_flag, overrun_flag;
  logic [5:0] presc;
  logic [4:0] q_cnt, seg_len;
  logic edge_seen, edge_pend;
  logic [3:0] rec_bits;
  logic [7:0] runs;
  logic from_busoff, prev_ep, prev_bo;
  logic [1:0] tx_cur;
  logic arb_hold;

  // sampled control fields
  logic early_transmit_select, no_retry_select, self_receive_enable;
  logic fast_resync_select, wake_pulse_select, run_req;
  assign early_transmit_select = ien[cpc_pkg::IEN_EARLY];
  assign no_retry_select = ctl[cpc_pkg::CTL_ONCE];
  assign self_receive_enable = ctl[cpc_pkg::CTL_SELF];
  assign fast_resync_select = ctl[cpc_pkg::CTL_FAST];
  assign wake_pulse_select = ctl[cpc_pkg::CTL_WAKE];
  assign run_req = ctl[cpc_pkg::CTL_RUN];

  // error state from counters
  logic bus_off_state, error_passive_state, error_pending;
  assign bus_off_state = tec[8];
  assign error_passive_state = !bus_off_state && (tec[7:0] > cpc_pkg::PASSIVE_LIM ||
                               rec > cpc_pkg::PASSIVE_LIM);
  assign error_pending = status_change_flag | overrun_flag | transmit_error_flag;

  // apb strobes
  logic wr_en, standby;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
  assign standby = (state == cpc_pkg::ST_STANDBY);
  logic wr_ist, wr_last;
  assign wr_ist = wr_en && paddr_in == cpc_pkg::ADDR_IST;
  assign wr_last = wr_en && paddr_in == cpc_pkg::ADDR_LAST_DATA;

  // bus pin synchroniser and edge view
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_d <= 1'b1;
    end else begin
      rx_m <= can_rx_in;
      rx_s <= rx_m;
      rx_d <= rx_s;
    end
  end

  // bit timing combinational terms
  logic tq_tick, valid_edge, edge_hit, sample_now, bit_end;
  logic [4:0] sjw, ext, len_one;
  assign tq_tick = !standby && presc == brpr[5:0];
  assign sjw = {3'h0, brpr[7:6]} + 5'h01;
  assign ext = (q_cnt < sjw) ? q_cnt : sjw;
  assign valid_edge = !rx_d && rx_s && !(state == cpc_pkg::ST_TX && can_tx_out);
  assign edge_hit = edge_pend || (valid_edge && !edge_seen);
  assign len_one = edge_hit ? seg_len + ext : seg_len;
  assign sample_now = tq_tick && seg == cpc_pkg::SEG_ONE && q_cnt >= len_one;
  assign bit_end = tq_tick && seg == cpc_pkg::SEG_TWO &&
                   (q_cnt >= seg_len || (edge_hit && seg_len - q_cnt <= sjw));

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || standby) begin
      presc <= 6'h00;
      seg <= cpc_pkg::SEG_SYNC;
      q_cnt <= 5'h00;
      seg_len <= 5'h00;
      edge_seen <= 1'b0;
      edge_pend <= 1'b0;
    end else begin
      presc <= tq_tick ? 6'h00 : presc + 6'h01;
      if (tq_tick)
        edge_pend <= 1'b0;
      else if (valid_edge && !edge_seen)
        edge_pend <= 1'b1;
      if (bit_end)
        edge_seen <= 1'b0;
      else if (valid_edge)
        edge_seen <= 1'b1;
      if (tq_tick) begin
        unique case (seg)
          cpc_pkg::SEG_SYNC: begin
            seg <= cpc_pkg::SEG_ONE;
            q_cnt <= 5'h01;
            seg_len <= {1'b0, btm[3:0]} + 5'h01;
          end
          cpc_pkg::SEG_ONE: begin
            if (sample_now) begin
              seg <= cpc_pkg::SEG_TWO;
              q_cnt <= 5'h01;
              seg_len <= {2'h0, btm[6:4]} + 5'h01;
            end else begin
              q_cnt <= q_cnt + 5'h01;
              seg_len <= len_one;
            end
          end
          cpc_pkg::SEG_TWO: begin
            if (bit_end) begin
              seg <= cpc_pkg::SEG_SYNC;
            end else begin
              q_cnt <= q_cnt + 5'h01;
              if (edge_hit)
                seg_len <= seg_len - sjw;
            end
          end
        endcase
      end
    end
  end

  // resync target and completion
  logic resync_done;
  logic [7:0] run_goal;
  assign run_goal = (fast_resync_select && !from_busoff) ? 8'h01 : 8'(RUN_COUNT);
  assign resync_done = sample_now && rx_s && rec_bits == 4'(RUN_BITS - 1) &&
                       runs + 8'h01 == run_goal;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || state != cpc_pkg::ST_RESYNC) begin
      rec_bits <= 4'h0;
      runs <= 8'h00;
    end else if (sample_now) begin
      if (!rx_s) begin
        rec_bits <= 4'h0;
      end else if (rec_bits == 4'(RUN_BITS - 1)) begin
        rec_bits <= 4'h0;
        runs <= runs + 8'h01;
      end else begin
        rec_bits <= rec_bits + 4'h1;
      end
    end
  end

  // transmit selection
  logic [2:0] want;
  logic any_want;
  logic [1:0] sel;
  assign want = pending & tx_job & lock;
  assign any_want = arb_hold || (|want);
  // buffer 3 first, then 2, then 1
  // early transmit keeps the arbitrating buffer
  always_comb begin
    sel = 2'd0;
    if (arb_hold)
      sel = tx_cur;
    else if (want[2])
      sel = 2'd2;
    else if (want[1])
      sel = 2'd1;
  end

  // core state machine
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state <= cpc_pkg::ST_STANDBY;
      from_busoff <= 1'b0;
    end else begin
      unique case (state)
        cpc_pkg::ST_STANDBY: begin
          // leave standby via wake or resync
          if (run_req) begin
            state <= wake_pulse_select ? cpc_pkg::ST_WAKE : cpc_pkg::ST_RESYNC;
            from_busoff <= 1'b0;
          end
        end
        cpc_pkg::ST_WAKE: begin
          if (!run_req)
            state <= cpc_pkg::ST_STANDBY;
          else if (bit_end)
            state <= cpc_pkg::ST_RESYNC;
        end
        cpc_pkg::ST_RESYNC: begin
          if (!run_req)
            state <= cpc_pkg::ST_STANDBY;
          else if (resync_done)
            state <= cpc_pkg::ST_IDLE;
        end
        cpc_pkg::ST_IDLE: begin
          if (bus_off_state) begin
            state <= cpc_pkg::ST_RESYNC;
            from_busoff <= 1'b1;
          end else if (!run_req)
            state <= cpc_pkg::ST_STANDBY;
          else if (fe_evt_in.sof)
            state <= cpc_pkg::ST_RX;
          else if (any_want)
            state <= cpc_pkg::ST_TX;
        end
        cpc_pkg::ST_TX: begin
          if (fe_evt_in.arb_lost)
            state <= cpc_pkg::ST_RX;
          else if (fe_evt_in.tx_ok || fe_evt_in.tx_err)
            state <= cpc_pkg::ST_IDLE;
        end
        cpc_pkg::ST_RX: begin
          if (fe_evt_in.rx_ok || fe_evt_in.rx_err)
            state <= cpc_pkg::ST_IDLE;
        end
        default: state <= cpc_pkg::ST_STANDBY;
      endcase
    end
  end

  // transmit job tracking and retry hold
  logic tx_start;
  assign tx_start = state == cpc_pkg::ST_IDLE && !bus_off_state && run_req &&
                    !fe_evt_in.sof && any_want;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tx_cur <= 2'd0;
      arb_hold <= 1'b0;
    end else begin
      if (tx_start)
        tx_cur <= sel;
      if (tx_start && early_transmit_select)
        arb_hold <= 1'b1;
      else if (fe_evt_in.arb_won || fe_evt_in.tx_err || no_retry_select ||
               bus_off_state || !lock[tx_cur])
        arb_hold <= 1'b0;
    end
  end

  // receive target search
  logic rx_take, rx_store;
  logic [1:0] rx_sel;
  logic rx_free;
  assign rx_take = (state == cpc_pkg::ST_RX || state == cpc_pkg::ST_TX) && fe_evt_in.rx_ok &&
                   fe_evt_in.filt != 2'd0 && (!fe_evt_in.own || self_receive_enable);
  always_comb begin
    rx_free = 1'b1;
    rx_sel = 2'd0;
    if (!lock[0] && !pending[0])
      rx_sel = 2'd0;
    else if (!lock[1] && !pending[1])
      rx_sel = 2'd1;
    else if (!lock[2] && !pending[2])
      rx_sel = 2'd2;
    else
      rx_free = 1'b0;
  end
  assign rx_store = rx_take && rx_free;

  logic in_tx, tx_fail_end;
  assign in_tx = state == cpc_pkg::ST_TX;
  // job ends on failure only with no retry
  assign tx_fail_end = in_tx && (fe_evt_in.tx_err || fe_evt_in.arb_lost) && no_retry_select;

  // per buffer status
  for (genvar i = 0; i < 3; i++) begin : g_buf
    logic me, wr_bc, sw_rel, done_ok;
    assign me = (tx_cur == 2'(i));
    assign wr_bc = wr_en && paddr_in == cpc_pkg::ADDR_BUF1 + 8'(4 * i);
    assign sw_rel = (wr_bc && !pwdata_in[cpc_pkg::BC_RDY]) ||
                    (wr_ist && !pwdata_in[cpc_pkg::IST_RX1 + i]);
    assign done_ok = in_tx && me && fe_evt_in.tx_ok;
    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        lock[i] <= 1'b0;
        pending[i] <= 1'b0;
        tx_job[i] <= 1'b0;
        busy[i] <= 1'b0;
        receive_flag[i] <= 1'b0;
        matched_filter_field[i] <= 2'd0;
      end else begin
        if (wr_bc)
          lock[i] <= pwdata_in[cpc_pkg::BC_LOCK];
        if (done_ok && early_transmit_select)
          lock[i] <= 1'b0;
        // pending from submission to job end
        if (sw_rel || done_ok || (me && tx_fail_end) || (tx_job[i] && bus_off_state) ||
            (tx_job[i] && !lock[i] && !busy[i])) begin
          pending[i] <= 1'b0;
          tx_job[i] <= 1'b0;
        end
        if (wr_last && page_select == 3'(i + 1) && lock[i]) begin
          pending[i] <= 1'b1;
          tx_job[i] <= 1'b1;
        end
        if (tx_start && sel == 2'(i))
          busy[i] <= 1'b1;
        else if (in_tx && me && (fe_evt_in.arb_lost || fe_evt_in.tx_ok || fe_evt_in.tx_err))
          busy[i] <= 1'b0;
        if (sw_rel)
          receive_flag[i] <= 1'b0;
        if (rx_store && rx_sel == 2'(i)) begin
          pending[i] <= 1'b1;
          receive_flag[i] <= 1'b1;
          matched_filter_field[i] <= fe_evt_in.filt;
        end
      end
    end
  end

  // error counters
  // increment and decrement per condition
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || (resync_done && from_busoff)) begin
      tec <= 9'h000;
      rec <= 8'h00;
    end else begin
      if (in_tx && fe_evt_in.tx_err && !tec[8])
        tec <= tec + cpc_pkg::TEC_STEP;
      else if (in_tx && fe_evt_in.tx_ok && tec != 9'h000)
        tec <= tec - 9'h001;
      if (state == cpc_pkg::ST_RX && fe_evt_in.rx_err && rec != 8'hff)
        rec <= rec + 8'h01;
      else if (state == cpc_pkg::ST_RX && fe_evt_in.rx_ok && rec != 8'h00)
        rec <= rec - 8'h01;
    end
  end

  // interrupt status flags, set beats clear
  logic st_change;
  assign st_change = !standby && (prev_ep != error_passive_state || prev_bo != bus_off_state);
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      transmit_done_flag <= 1'b0;
      transmit_error_flag <= 1'b0;
      status_change_flag <= 1'b0;
      overrun_flag <= 1'b0;
      prev_ep <= 1'b0;
      prev_bo <= 1'b0;
      last_ident <= 11'h000;
    end else begin
      prev_ep <= error_passive_state;
      prev_bo <= bus_off_state;
      if (wr_ist && !pwdata_in[cpc_pkg::IST_TXDN])
        transmit_done_flag <= 1'b0;
      if (wr_ist && !pwdata_in[cpc_pkg::IST_TERR])
        transmit_error_flag <= 1'b0;
      if (wr_ist && !pwdata_in[cpc_pkg::IST_STCH])
        status_change_flag <= 1'b0;
      if (wr_ist && !pwdata_in[cpc_pkg::IST_OVR])
        overrun_flag <= 1'b0;
      // done flag, or at arbitration with early transmit
      if (in_tx && (early_transmit_select ? fe_evt_in.arb_won : fe_evt_in.tx_ok))
        transmit_done_flag <= 1'b1;
      if (in_tx && fe_evt_in.tx_err || tx_fail_end)
        transmit_error_flag <= 1'b1;
      if ((standby && rx_d && !rx_s) || st_change ||
          (ien[cpc_pkg::IEN_RXERR] && state == cpc_pkg::ST_RX && fe_evt_in.rx_err))
        status_change_flag <= 1'b1;
      if (rx_take && !rx_free)
        overrun_flag <= 1'b1;
      if ((state == cpc_pkg::ST_RX || in_tx) && fe_evt_in.rx_ok)
        last_ident <= fe_evt_in.id;
    end
  end

  // control registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ien <= cpc_pkg::IEN_RST;
      ctl <= cpc_pkg::CTL_RST;
      brpr <= cpc_pkg::BRPR_RST;
      btm <= cpc_pkg::BTM_RST;
      page_select <= 3'h0;
    end else if (wr_en) begin
      unique case (paddr_in)
        cpc_pkg::ADDR_IEN: ien <= {1'b0, pwdata_in[6:0]};
        cpc_pkg::ADDR_CTL: ctl <= {3'h0, pwdata_in[4:0]};
        cpc_pkg::ADDR_BRPR: if (standby) brpr <= pwdata_in[7:0];
        cpc_pkg::ADDR_BTM: if (standby) btm <= {1'b0, pwdata_in[6:0]};
        cpc_pkg::ADDR_PAGE: page_select <= pwdata_in[2:0];
        default: ;
      endcase
    end
  end

  // apb read and answer, no wait state
  logic [31:0] rd;
  logic rd_err;
  always_comb begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr_in)
      cpc_pkg::ADDR_IST: rd[7:0] = {receive_flag[2], receive_flag[1], receive_flag[0],
                                    transmit_done_flag, status_change_flag, overrun_flag,
                                    transmit_error_flag, error_pending};
      cpc_pkg::ADDR_IEN: rd[7:0] = ien;
      // run reads 1 until standby reached
      cpc_pkg::ADDR_CTL: rd[7:0] = {1'b0, bus_off_state, error_passive_state, ctl[4:1],
                                    run_req || !standby};
      cpc_pkg::ADDR_BRPR: rd[7:0] = brpr;
      cpc_pkg::ADDR_BTM: rd[7:0] = btm;
      cpc_pkg::ADDR_TEC: rd[8:0] = tec;
      cpc_pkg::ADDR_REC: rd[7:0] = rec;
      cpc_pkg::ADDR_LID: rd[10:0] = last_ident;
      cpc_pkg::ADDR_PAGE: rd[2:0] = page_select;
      cpc_pkg::ADDR_LAST_DATA: rd = 32'h0000_0000;
      cpc_pkg::ADDR_BUF1: rd[4:0] = {matched_filter_field[0], busy[0], lock[0], pending[0]};
      cpc_pkg::ADDR_BUF2: rd[4:0] = {matched_filter_field[1], busy[1], lock[1], pending[1]};
      cpc_pkg::ADDR_BUF3: rd[4:0] = {matched_filter_field[2], busy[2], lock[2], pending[2]};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      if (psel_in && !penable_in) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd;
        pslverr_out <= rd_err;
      end
    end
  end

  // pin, frame engine and interrupt outputs
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      can_tx_out <= 1'b1;
      fe_ctl_out <= '0;
      irq_out <= 1'b0;
    end else begin
      if (state == cpc_pkg::ST_WAKE)
        can_tx_out <= 1'b0;
      else if (in_tx || state == cpc_pkg::ST_RX)
        can_tx_out <= fe_evt_in.tx_bit;
      else
        can_tx_out <= 1'b1;
      fe_ctl_out.tx_start <= tx_start;
      fe_ctl_out.tx_buf <= sel;
      fe_ctl_out.sample <= sample_now;
      fe_ctl_out.bit_val <= rx_s;
      fe_ctl_out.tx_point <= bit_end;
      fe_ctl_out.active <= state == cpc_pkg::ST_IDLE || in_tx || state == cpc_pkg::ST_RX;
      irq_out <= (|receive_flag && ien[cpc_pkg::IEN_RX]) ||
                 (transmit_done_flag && ien[cpc_pkg::IEN_TX]) ||
                 (transmit_error_flag && ien[cpc_pkg::IEN_TERR]) ||
                 (overrun_flag && ien[cpc_pkg::IEN_OVR]) ||
                 (status_change_flag && ien[cpc_pkg::IEN_STCH]);
    end
  end
endmodule : cpc_core
`default_nettype wire

// ### bench/cpc_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpc_bus_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // core side
  input wire logic can_tx_in,
  input wire cpc_pkg::cpc_fe_ctl_t fe_ctl_in,
  // bus and frame engine answers
  output wire logic can_rx_out,
  output wire cpc_pkg::cpc_fe_evt_t fe_evt_out
);
  int step = 0;
  // wired-and bus with pull-up, so an undriven line reads recessive
  assign can_rx_out = (can_tx_in !== 1'b0);
  // frame engine: arbitration won after 3 cycles, success after 6
  assign fe_evt_out = '{arb_won: (step == 3), tx_ok: (step == 6), tx_bit: 1'b1, default: '0};
  // step through one frame per start pulse
  always @(posedge clk_sys_in) begin
    if (!rstn_in || step == 6) begin
      step <= 0;
    end else if (fe_ctl_in.tx_start) begin
      step <= 1;
    end else if (step != 0) begin
      step <= step + 1;
    end
  end
endmodule : cpc_bus_model
`default_nettype wire

// ### bench/cpc_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cpc_core_sva #(
  parameter int RUN_BITS = 11,
  parameter int RUN_COUNT = 128
) (
  // watched ports
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic can_rx_in,
  input wire logic can_tx_out,
  input wire cpc_pkg::cpc_fe_evt_t fe_evt_in,
  input wire cpc_pkg::cpc_fe_ctl_t fe_ctl_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  reset_quiet_a: assert property ($rose(rstn_in) |->
    can_tx_out && !irq_out && !pready_out && fe_ctl_out == '0) else $error("not quiet after reset");
  ready_after_setup_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready too long");
  unmapped_err_a: assert property (pready_out && paddr_in > 8'h30 |->
    pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
  upper_zero_a: assert property (pready_out |-> prdata_out[31:11] == 21'h0 &&
    (paddr_in == 8'h14 || paddr_in == 8'h1c || prdata_out[10:8] == 3'h0))
    else $error("upper read bits set");
  pending_sum_a: assert property (pready_out && !pwrite_in && paddr_in == 8'h00 |->
    prdata_out[0] == (|prdata_out[3:1])) else $error("error pending wrong");
  start_active_a: assert property (fe_ctl_out.tx_start |-> fe_ctl_out.active)
    else $error("start while inactive");
  start_pulse_a: assert property (fe_ctl_out.tx_start |=> !fe_ctl_out.tx_start)
    else $error("start pulse too long");
  cover property (fe_ctl_out.tx_start);
  cover property (pslverr_out);
  cover property (irq_out);
endmodule : cpc_core_sva
bind cpc_core cpc_core_sva #(.RUN_BITS(RUN_BITS), .RUN_COUNT(RUN_COUNT)) i_sva (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .can_rx_in(can_rx_in),
  .can_tx_out(can_tx_out), .fe_evt_in(fe_evt_in), .fe_ctl_out(fe_ctl_out), .irq_out(irq_out));
`default_nettype wire

// ### bench/can_protocol_core_modes_test.sv
`timescale 1ns/100ps
`default_nettype none
module can_protocol_core_modes_test;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, can_rx_in, can_tx_out, irq_out, err;
  cpc_pkg::cpc_fe_evt_t fe_evt_in;
  cpc_pkg::cpc_fe_ctl_t fe_ctl_out;
  int bad_count = 0, total_checks = 0, cycles = 0, n;
  time t0;
  logic [39:0] rows [7] = '{40'h00_00000000, 40'h04_00000000, 40'h08_00000000, 40'h0c_00000000,
    40'h10_00000023, 40'h14_00000000, 40'h18_00000000};
  cpc_core #(.RUN_COUNT(2)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .can_rx_in(can_rx_in), .can_tx_out(can_tx_out), .fe_evt_in(fe_evt_in),
    .fe_ctl_out(fe_ctl_out), .irq_out(irq_out));
  cpc_bus_model i_bus (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .can_tx_in(can_tx_out),
    .fe_ctl_in(fe_ctl_out), .can_rx_out(can_rx_in), .fe_evt_out(fe_evt_in));
  // clock and hang guard
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, read data left in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_start(input logic [1:0] b);
    n = 0;
    while (fe_ctl_out.tx_start !== 1'b1 && n < 3000) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk({29'h0, fe_ctl_out.tx_start, fe_ctl_out.tx_buf}, {29'h0, 1'b1, b});
    @(posedge clk_sys_in);
  endtask : wait_start
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    foreach (rows[i]) begin
      rdchk(rows[i][39:32], rows[i][31:0]);
    end
    $display("reset values done");
    apb(1'b1, 8'h10, 32'h24);
    rdchk(8'h10, 32'h24);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("standby timing and unmapped done");
    // run with fast resync, queue buffer 1 then 3 meanwhile
    apb(1'b1, 8'h04, 32'h10);
    t0 = $time;
    apb(1'b1, 8'h08, 32'h05);
    apb(1'b1, 8'h28, 32'h02);
    rdchk(8'h28, 32'h02);
    apb(1'b1, 8'h20, 32'h01);
    apb(1'b1, 8'h24, 32'h00);
    apb(1'b1, 8'h30, 32'h02);
    apb(1'b1, 8'h20, 32'h03);
    apb(1'b1, 8'h24, 32'h00);
    while (fe_ctl_out.active !== 1'b1 && $time < t0 + 64'd8000) @(posedge clk_sys_in);
    chk({30'h0, fe_ctl_out.active, ($time - t0) >= 64'd792}, 32'h3);
    wait_start(2'd2);
    wait_start(2'd0);
    repeat (20) @(posedge clk_sys_in);
    rdchk(8'h00, 32'h10);
    chk({31'h0, irq_out}, 32'h1);
    rdchk(8'h28, 32'h02);
    rdchk(8'h30, 32'h02);
    apb(1'b1, 8'h10, 32'h33);
    rdchk(8'h10, 32'h24);
    $display("transmit priority done");
    apb(1'b1, 8'h00, 32'h00);
    rdchk(8'h00, 32'h00);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, 8'h08, 32'h04);
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    chk({31'h0, rd[0]}, 32'h0);
    $display("flag clear and standby done");
    end_sim();
  end
endmodule : can_protocol_core_modes_test
`default_nettype wire
